// ### hdl/ramp_status_pkg.sv
package ramp_status_pkg;
  // register indices; byte address is index times four
  localparam logic [7:0] IDX_LATCHED_RAMP_POSITION = 8'h36;
  localparam logic [7:0] IDX_RAMP_STATUS = 8'h35;
  localparam logic [7:0] IDX_SWITCH_CONFIG = 8'h34;
  localparam logic [7:0] IDX_RAMP_CONTROL = 8'h33;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h37;
  localparam logic [9:0] ADDR_LATCHED_RAMP_POSITION =
    {IDX_LATCHED_RAMP_POSITION, 2'b00};
  localparam logic [9:0] ADDR_RAMP_STATUS = {IDX_RAMP_STATUS, 2'b00};
  localparam logic [9:0] ADDR_SWITCH_CONFIG = {IDX_SWITCH_CONFIG, 2'b00};
  localparam logic [9:0] ADDR_RAMP_CONTROL = {IDX_RAMP_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // status bit positions
  localparam int BIT_STOP_L = 0;
  localparam int BIT_STOP_R = 1;
  localparam int BIT_LATCH_L = 2;
  localparam int BIT_LATCH_R = 3;
  localparam int BIT_EV_STOP_L = 4;
  localparam int BIT_EV_STOP_R = 5;
  localparam int BIT_EV_STALL = 6;
  localparam int BIT_EV_POS = 7;
  localparam int BIT_VEL_HIT = 8;
  localparam int BIT_POS_HIT = 9;
  // switch_config bit positions
  localparam int CFG_STOP_L_EN = 0;
  localparam int CFG_STOP_R_EN = 1;
  localparam int CFG_LATCH_L_ACT = 2;
  localparam int CFG_LATCH_L_INACT = 3;
  localparam int CFG_LATCH_R_ACT = 4;
  localparam int CFG_LATCH_R_INACT = 5;
  localparam int CFG_STALL_EN = 6;
  localparam int CFG_GENTLE_STOP = 7;
  localparam int CFG_WIDTH = 8;
  localparam logic [15:0] STATUS_W1C_MASK = 16'h00CC;
  localparam logic [15:0] STATUS_EVENT_MASK = 16'h00F0;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h00F0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] actual_position;
    logic [31:0] target_position;
    logic [31:0] actual_velocity;
    logic [31:0] max_velocity;
    logic hold_mode;
    logic move_left;
    logic move_right;
    logic motor_moving;
    logic stall_detect;
  } ramp_view_t;

  typedef struct packed {
    logic stop_l;
    logic stop_r;
    logic virt_stop_l;
    logic virt_stop_r;
  } switch_pins_t;
endpackage : ramp_status_pkg

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import ramp_status_pkg::*;
#(
  parameter int WIDTH = 2
)(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
  } sync_state_t;
  sync_state_t state_ff;
  sync_state_t nxt_state;

  if (WIDTH < 1)
  begin : g_width_check
    $error("pin_sync: WIDTH must be at least 1");
  end

  always_comb
  begin
    nxt_state.meta_ff = async_in;
    nxt_state.sync_ff = state_ff.meta_ff;
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.sync_ff;
endmodule : pin_sync
`default_nettype wire

// ### hdl/ramp_status_and_position_latch.sv
// Behaviour
// R1: status bit 8 high while actual velocity equals max velocity.
// R2: bit 7 set when target-arrived rises; write 1 clears it.
// R3: interrupt is OR of event bits 7, 6, 5, 4, each gated by its IRQ mask bit.
// R4: bit 6 set on stall stop; write 1 clears it and stall.
// R5: bit 5 / bit 4 raised on right / left stop activation.
// R6: hold mode or opposite-direction move removes stop condition.
// R7: gentle stop keeps stop active until motion toward switch ends.
// R8: disabling stop switch or function clears stop event bit.
// R9: bit 3 set on right switch latch per edge selects; W1C.
// R10: bit 2 set on left switch latch per edge selects; W1C.
// R11: bit 1 live right switch, bit 0 live left switch.
// R12: 32-bit read-only latch at index 0x36 captures actual position.
// R13: software may pair encoder latch with ramp latch for checks.
// R14: status bit 9 high while actual position equals target.
// R15: arrival event only on rising edge of target-arrived status.
`timescale 1ns/1ps
`default_nettype none
module ramp_status_and_position_latch
  import ramp_status_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [9:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // ramp generator view
  input wire ramp_view_t RAMP_IN,
  // switch pins
  input wire switch_pins_t SWITCH_IN,
  // stop requests to ramp generator
  output logic STOP_L_OUT,
  output logic STOP_R_OUT,
  output logic STALL_HALT_OUT,
  // interrupt
  output logic IRQ_OUT
);
  typedef struct packed {
    logic [15:0] status_ff;
    logic [15:0] irq_mask_ff;
    logic [CFG_WIDTH-1:0] switch_config_ff;
    logic [31:0] latched_ramp_position_ff;
    logic pos_hit_d_ff;
    logic stop_l_d_ff;
    logic stop_r_d_ff;
    logic [31:0] prdata_ff;
    logic irq_ff;
  } core_state_t;
  core_state_t state_ff;
  core_state_t nxt_state;

  default clocking sample_cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  logic [3:0] sw_sync;
  logic stop_l_lvl;
  logic stop_r_lvl;
  logic stop_l_on;
  logic stop_r_on;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic pos_hit;
  logic vel_hit;
  logic latch_l_evt;
  logic latch_r_evt;
  logic [15:0] w1c;

  pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .CLOCK_IN(CLOCK_IN),
    .RST_N_IN(RST_N_IN),
    .async_in({SWITCH_IN.virt_stop_r, SWITCH_IN.virt_stop_l,
               SWITCH_IN.stop_r, SWITCH_IN.stop_l}),
    .sync_out(sw_sync)
  );

  assign stop_l_lvl = sw_sync[0];
  assign stop_r_lvl = sw_sync[1];
  // physical or virtual stop, gated by enable
  assign stop_l_on = (stop_l_lvl | sw_sync[2])
    & state_ff.switch_config_ff[CFG_STOP_L_EN];
  assign stop_r_on = (stop_r_lvl | sw_sync[3])
    & state_ff.switch_config_ff[CFG_STOP_R_EN];

  assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_acc = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign addr_ok = (PADDR_IN == ADDR_LATCHED_RAMP_POSITION)
    | (PADDR_IN == ADDR_RAMP_STATUS) | (PADDR_IN == ADDR_SWITCH_CONFIG)
    | (PADDR_IN == ADDR_IRQ_MASK);

  assign pos_hit = RAMP_IN.actual_position == RAMP_IN.target_position; // R14
  assign vel_hit = RAMP_IN.actual_velocity == RAMP_IN.max_velocity; // R1

  // latch event per edge selects
  assign latch_l_evt =
    (state_ff.switch_config_ff[CFG_LATCH_L_ACT]
      & stop_l_lvl & ~state_ff.stop_l_d_ff)
    | (state_ff.switch_config_ff[CFG_LATCH_L_INACT]
      & ~stop_l_lvl & state_ff.stop_l_d_ff);
  assign latch_r_evt =
    (state_ff.switch_config_ff[CFG_LATCH_R_ACT]
      & stop_r_lvl & ~state_ff.stop_r_d_ff)
    | (state_ff.switch_config_ff[CFG_LATCH_R_INACT]
      & ~stop_r_lvl & state_ff.stop_r_d_ff);

  assign w1c = (wr_acc && PADDR_IN == ADDR_RAMP_STATUS)
    ? (PWDATA_IN[15:0] & STATUS_W1C_MASK) : 16'h0000;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.pos_hit_d_ff = pos_hit;
    nxt_state.stop_l_d_ff = stop_l_lvl;
    nxt_state.stop_r_d_ff = stop_r_lvl;
    // clears first, sets after so a set wins
    nxt_state.status_ff = state_ff.status_ff & ~w1c; // R2 R4 R9 R10
    // stop events: removed by hold, opposite move or disable
    if (RAMP_IN.hold_mode || RAMP_IN.move_right || !stop_l_on) // R6 R8
    begin
      if (!(state_ff.switch_config_ff[CFG_GENTLE_STOP]
            && RAMP_IN.motor_moving && !RAMP_IN.move_right
            && stop_l_on)) // R7
      begin
        nxt_state.status_ff[BIT_EV_STOP_L] = 1'b0;
      end
    end
    if (RAMP_IN.hold_mode || RAMP_IN.move_left || !stop_r_on) // R6 R8
    begin
      if (!(state_ff.switch_config_ff[CFG_GENTLE_STOP]
            && RAMP_IN.motor_moving && !RAMP_IN.move_left
            && stop_r_on)) // R7
      begin
        nxt_state.status_ff[BIT_EV_STOP_R] = 1'b0;
      end
    end
    if (stop_l_on && RAMP_IN.move_left && !RAMP_IN.hold_mode)
    begin
      nxt_state.status_ff[BIT_EV_STOP_L] = 1'b1; // R5
    end
    if (stop_r_on && RAMP_IN.move_right && !RAMP_IN.hold_mode)
    begin
      nxt_state.status_ff[BIT_EV_STOP_R] = 1'b1; // R5
    end
    if (RAMP_IN.stall_detect && state_ff.switch_config_ff[CFG_STALL_EN])
    begin
      nxt_state.status_ff[BIT_EV_STALL] = 1'b1; // R4
    end
    if (pos_hit && !state_ff.pos_hit_d_ff)
    begin
      nxt_state.status_ff[BIT_EV_POS] = 1'b1; // R2 R15
    end
    if (latch_l_evt || latch_r_evt)
    begin
      nxt_state.latched_ramp_position_ff = RAMP_IN.actual_position; // R12
    end
    if (latch_l_evt)
    begin
      nxt_state.status_ff[BIT_LATCH_L] = 1'b1; // R10
    end
    if (latch_r_evt)
    begin
      nxt_state.status_ff[BIT_LATCH_R] = 1'b1; // R9
    end
    nxt_state.status_ff[BIT_STOP_L] = stop_l_lvl; // R11
    nxt_state.status_ff[BIT_STOP_R] = stop_r_lvl; // R11
    nxt_state.status_ff[BIT_VEL_HIT] = vel_hit; // R1
    nxt_state.status_ff[BIT_POS_HIT] = pos_hit; // R14
    // register writes
    if (wr_acc && PADDR_IN == ADDR_SWITCH_CONFIG)
    begin
      nxt_state.switch_config_ff = PWDATA_IN[CFG_WIDTH-1:0];
    end
    if (wr_acc && PADDR_IN == ADDR_IRQ_MASK)
    begin
      nxt_state.irq_mask_ff = PWDATA_IN[15:0] & STATUS_EVENT_MASK;
    end
    // read data in setup phase
    if (rd_acc)
    begin
      case (PADDR_IN)
        ADDR_LATCHED_RAMP_POSITION:
          nxt_state.prdata_ff = state_ff.latched_ramp_position_ff;
        ADDR_RAMP_STATUS:
          nxt_state.prdata_ff = {16'h0000, state_ff.status_ff};
        ADDR_SWITCH_CONFIG:
          nxt_state.prdata_ff = {24'h000000, state_ff.switch_config_ff};
        ADDR_IRQ_MASK:
          nxt_state.prdata_ff = {16'h0000, state_ff.irq_mask_ff};
        default:
          nxt_state.prdata_ff = ZERO_WORD;
      endcase
    end
    nxt_state.irq_ff = |(nxt_state.status_ff & STATUS_EVENT_MASK
      & nxt_state.irq_mask_ff); // R3
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_ff <= '0;
      state_ff.irq_mask_ff <= IRQ_MASK_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign PRDATA_OUT = state_ff.prdata_ff;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
  assign STOP_L_OUT = state_ff.status_ff[BIT_EV_STOP_L];
  assign STOP_R_OUT = state_ff.status_ff[BIT_EV_STOP_R];
  assign STALL_HALT_OUT = state_ff.status_ff[BIT_EV_STALL]; // R4
  assign IRQ_OUT = state_ff.irq_ff;

  AST_VEL_HIT: assert property ( // R1
    state_ff.status_ff[BIT_VEL_HIT] == $past(vel_hit))
    else $error("velocity hit bit wrong");
  AST_POS_HIT: assert property ( // R14
    state_ff.status_ff[BIT_POS_HIT] == $past(pos_hit))
    else $error("position hit bit wrong");
  AST_POS_EVENT: assert property ( // R2
    (pos_hit && !state_ff.pos_hit_d_ff) |=> state_ff.status_ff[BIT_EV_POS])
    else $error("arrival event not set");
  AST_POS_CLR: assert property ( // R2
    (w1c[BIT_EV_POS] && !(pos_hit && !state_ff.pos_hit_d_ff))
    |=> !state_ff.status_ff[BIT_EV_POS])
    else $error("arrival event not cleared");
  AST_NO_RERAISE: assert property ( // R15
    (!state_ff.status_ff[BIT_EV_POS] && state_ff.pos_hit_d_ff && pos_hit)
    |=> !state_ff.status_ff[BIT_EV_POS])
    else $error("arrival event re-raised");
  AST_IRQ_OR: assert property ( // R3
    IRQ_OUT == |(state_ff.status_ff & STATUS_EVENT_MASK
      & state_ff.irq_mask_ff))
    else $error("interrupt not OR of events");
  AST_STALL_SET: assert property ( // R4
    (RAMP_IN.stall_detect && state_ff.switch_config_ff[CFG_STALL_EN])
    |=> STALL_HALT_OUT)
    else $error("stall stop not raised");
  AST_STALL_CLR: assert property ( // R4
    (w1c[BIT_EV_STALL] && !RAMP_IN.stall_detect) |=> !STALL_HALT_OUT)
    else $error("stall not cleared");
  AST_STOP_R_SET: assert property ( // R5
    (stop_r_on && RAMP_IN.move_right && !RAMP_IN.hold_mode)
    |=> state_ff.status_ff[BIT_EV_STOP_R])
    else $error("right stop not raised");
  AST_STOP_L_SET: assert property ( // R5
    (stop_l_on && RAMP_IN.move_left && !RAMP_IN.hold_mode)
    |=> state_ff.status_ff[BIT_EV_STOP_L])
    else $error("left stop not raised");
  AST_HOLD_CLR: assert property ( // R6
    (RAMP_IN.hold_mode && !RAMP_IN.motor_moving) |=> !(STOP_L_OUT || STOP_R_OUT))
    else $error("hold did not clear stop");
  AST_OPPOSITE: assert property ( // R6
    (RAMP_IN.move_right && !RAMP_IN.move_left
     && !state_ff.switch_config_ff[CFG_GENTLE_STOP]) |=> !STOP_L_OUT)
    else $error("opposite move did not clear stop");
  AST_GENTLE: assert property ( // R7
    (STOP_R_OUT && stop_r_on && RAMP_IN.motor_moving && !RAMP_IN.move_left
     && state_ff.switch_config_ff[CFG_GENTLE_STOP]) |=> STOP_R_OUT)
    else $error("gentle stop dropped early");
  AST_DISABLE: assert property ( // R8
    !stop_l_on |=> !STOP_L_OUT)
    else $error("disabled stop still set");
  AST_DISABLE_R: assert property ( // R8
    !stop_r_on |=> !STOP_R_OUT)
    else $error("disabled right stop still set");
  AST_LATCH_R: assert property ( // R9
    latch_r_evt |=> (state_ff.status_ff[BIT_LATCH_R]
      && state_ff.latched_ramp_position_ff == $past(RAMP_IN.actual_position)))
    else $error("right latch wrong");
  AST_LATCH_L: assert property ( // R10
    latch_l_evt |=> state_ff.status_ff[BIT_LATCH_L])
    else $error("left latch flag not set");
  AST_LIVE_SW: assert property ( // R11
    state_ff.status_ff[BIT_STOP_R] == $past(stop_r_lvl))
    else $error("live switch bit wrong");
  AST_LIVE_SW_L: assert property ( // R11
    state_ff.status_ff[BIT_STOP_L] == $past(stop_l_lvl))
    else $error("live left switch bit wrong");
  AST_LATCH_HOLD: assert property ( // R12
    !(latch_l_evt || latch_r_evt)
    |=> $stable(state_ff.latched_ramp_position_ff))
    else $error("latch changed without event");
  COV_POS: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    $rose(state_ff.status_ff[BIT_EV_POS]));
  COV_STALL: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    $rose(STALL_HALT_OUT));
  COV_LATCH: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    latch_l_evt);
  COV_IRQ: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    $fell(IRQ_OUT));
  COV_GENTLE: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    STOP_R_OUT && RAMP_IN.hold_mode
    && state_ff.switch_config_ff[CFG_GENTLE_STOP]);
endmodule : ramp_status_and_position_latch
`default_nettype wire

// ### tb/ramp_status_and_position_latch_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ramp_status_and_position_latch_bench
  import ramp_status_pkg::*;
;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [9:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ramp_view_t ramp;
  switch_pins_t sw;
  logic stop_l;
  logic stop_r;
  logic stall_halt;
  logic irq;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checks = 0;

  ramp_status_and_position_latch ramp_status_and_position_latch_i (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RAMP_IN(ramp), .SWITCH_IN(sw),
    .STOP_L_OUT(stop_l), .STOP_R_OUT(stop_r),
    .STALL_HALT_OUT(stall_halt), .IRQ_OUT(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // one apb transfer, waits for pready
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, ADDR_RAMP_STATUS, 32'h0);
    chk(rd & m, e);
  endtask : st

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done;
  end

  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ramp = '0;
    ramp.actual_position = 32'h0000_0010;
    ramp.target_position = 32'h0000_0020;
    ramp.actual_velocity = 32'h0000_0001;
    ramp.max_velocity = 32'h0000_0002;
    sw = '0;
    wt(12);
    rst_n <= 1'b1;
    st(32'h0000_03FF, 32'h0);
    xfer(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(rd & 32'h0000_00F0, 32'h0000_00F0);
    xfer(1'b0, 10'h000, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // arrival and velocity hit
    ramp.actual_position <= 32'h0000_0020;
    ramp.actual_velocity <= 32'h0000_0002;
    wt(4);
    st(32'h0000_0380, 32'h0000_0380);
    chk(irq, 1);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
    wt(3);
    chk(irq, 0);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h0000_00F0);
    xfer(1'b1, ADDR_RAMP_STATUS, 32'h0000_0080);
    wt(3);
    st(32'h0000_0380, 32'h0000_0300);
    chk(irq, 0);
    ramp.actual_position <= 32'h0000_0010;
    ramp.actual_velocity <= 32'h0000_0001;
    wt(3);
    st(32'h0000_0300, 32'h0);
    // stall stop
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0040);
    ramp.stall_detect <= 1'b1;
    wt(1);
    ramp.stall_detect <= 1'b0;
    wt(3);
    st(32'h0000_0040, 32'h0000_0040);
    chk({irq, stall_halt}, 2'b11);
    xfer(1'b1, ADDR_RAMP_STATUS, 32'h0000_0040);
    wt(3);
    st(32'h0000_0040, 32'h0);
    chk({irq, stall_halt}, 2'b00);
    // right stop removed by hold
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0002);
    ramp.move_right <= 1'b1;
    ramp.motor_moving <= 1'b1;
    sw.stop_r <= 1'b1;
    wt(6);
    st(32'h0000_0033, 32'h0000_0022);
    chk({irq, stop_r}, 2'b11);
    ramp.hold_mode <= 1'b1;
    wt(4);
    st(32'h0000_0020, 32'h0);
    chk(stop_r, 0);
    sw.stop_r <= 1'b0;
    ramp.hold_mode <= 1'b0;
    wt(6);
    // left stop removed by opposite move
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0001);
    ramp.move_right <= 1'b0;
    ramp.move_left <= 1'b1;
    sw.stop_l <= 1'b1;
    wt(6);
    st(32'h0000_0033, 32'h0000_0011);
    chk({irq, stop_l}, 2'b11);
    ramp.move_left <= 1'b0;
    ramp.move_right <= 1'b1;
    wt(4);
    st(32'h0000_0010, 32'h0);
    chk(stop_l, 0);
    sw.stop_l <= 1'b0;
    // disable clears right stop
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0002);
    sw.stop_r <= 1'b1;
    wt(6);
    st(32'h0000_0020, 32'h0000_0020);
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0);
    wt(3);
    st(32'h0000_0020, 32'h0);
    chk({irq, stop_r}, 2'b00);
    // gentle stop holds until motion ends
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0082);
    wt(4);
    st(32'h0000_0020, 32'h0000_0020);
    ramp.hold_mode <= 1'b1;
    wt(4);
    st(32'h0000_0020, 32'h0000_0020);
    ramp.motor_moving <= 1'b0;
    wt(4);
    st(32'h0000_0020, 32'h0);
    sw.stop_r <= 1'b0;
    ramp.hold_mode <= 1'b0;
    ramp.move_right <= 1'b0;
    // right latch on active edge
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0010);
    ramp.actual_position <= 32'hA5A5_0001;
    wt(2);
    sw.stop_r <= 1'b1;
    wt(6);
    ramp.actual_position <= 32'h0000_1234;
    st(32'h0000_000C, 32'h0000_0008);
    xfer(1'b1, ADDR_LATCHED_RAMP_POSITION, 32'hFFFF_FFFF);
    xfer(1'b0, ADDR_LATCHED_RAMP_POSITION, 32'h0);
    chk(rd, 32'hA5A5_0001);
    xfer(1'b1, ADDR_RAMP_STATUS, 32'h0000_0008);
    wt(2);
    st(32'h0000_000C, 32'h0);
    sw.stop_r <= 1'b0;
    // left latch on inactive edge
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0008);
    sw.stop_l <= 1'b1;
    wt(6);
    st(32'h0000_000D, 32'h0000_0001);
    ramp.actual_position <= 32'h0000_7777;
    wt(2);
    sw.stop_l <= 1'b0;
    wt(6);
    st(32'h0000_000D, 32'h0000_0004);
    xfer(1'b0, ADDR_LATCHED_RAMP_POSITION, 32'h0);
    chk(rd, 32'h0000_7777);
    xfer(1'b1, ADDR_RAMP_STATUS, 32'h0000_0004);
    wt(2);
    st(32'h0000_00FF, 32'h0);
    chk(irq, 0);
    // left latch on active edge, right latch on inactive edge
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0024);
    ramp.actual_position <= 32'h0000_0BAD;
    wt(2);
    sw.stop_l <= 1'b1;
    sw.stop_r <= 1'b1;
    wt(6);
    st(32'h0000_000F, 32'h0000_0007);
    xfer(1'b0, ADDR_LATCHED_RAMP_POSITION, 32'h0);
    chk(rd, 32'h0000_0BAD);
    ramp.actual_position <= 32'h0000_0C0D;
    wt(2);
    sw.stop_r <= 1'b0;
    wt(6);
    st(32'h0000_000F, 32'h0000_000D);
    xfer(1'b0, ADDR_LATCHED_RAMP_POSITION, 32'h0);
    chk(rd, 32'h0000_0C0D);
    // virtual left stop, then hold
    xfer(1'b1, ADDR_RAMP_STATUS, 32'h0000_000C);
    xfer(1'b1, ADDR_SWITCH_CONFIG, 32'h0000_0001);
    sw.stop_l <= 1'b0;
    ramp.move_left <= 1'b1;
    sw.virt_stop_l <= 1'b1;
    wt(6);
    st(32'h0000_001F, 32'h0000_0010);
    chk({irq, stop_l}, 2'b11);
    sw.virt_stop_l <= 1'b0;
    ramp.move_left <= 1'b0;
    ramp.hold_mode <= 1'b1;
    wt(4);
    st(32'h0000_0010, 32'h0);
    chk({irq, stop_l}, 2'b00);
    test_done;
  end
endmodule : ramp_status_and_position_latch_bench
`default_nettype wire
